// >>> hw/autoneg_nextpage_mmd_regs.sv
// Register group for partner ability, expansion, next pages and indirect access
`timescale 1ns/100ps
// Summary of operation
// - Partner pause field read-only at bits 11:10
// - Partner T4 at bit 9, never local
// - Partner speed abilities bits 8:5, clear after reset
// - Acknowledge bit 14 set after code word
// - Partner remote fault at bit 13
// - Expansion bits 6 and 5 read one
// - Parallel detection fault latched until read
// - Partner next page able at bit 3
// - Local next page able reads one
// - Page received latched until read
// - Partner negotiation able at bit 0
// - Transmit page writable fields with reset values
// - Toggle bits read-only, inverse of previous
// - Receive page fields read-only, zero at reset
// - Function field selects address or data
// - Five-bit device select at bits 4:0
// - Function zero writes address, else data
module autoneg_nextpage_mmd_regs
  import an_regs_pkg::*;
(
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0]    avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  output logic      [1:0]           avs_response,
  // Negotiation engine side
  input  wire partner_base_t        partner_in,
  input  wire logic                 partner_load,
  input  wire page_t                rx_page_in,
  input  wire logic                 rx_page_load,
  input  wire expansion_in_t        exp_in,
  input  wire logic                 tx_page_sent,
  // Indirect device access side
  output logic      [4:0]           target_device_select,
  output logic      [15:0]          indirect_address,
  output logic                      indirect_wr,
  output logic      [15:0]          indirect_wdata,
  input  wire logic [15:0]          indirect_rdata,
  // Interrupt
  output logic                      irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  partner_base_t      partner;
  page_t              rx_page;
  page_t              tx_page;
  logic               tx_toggle_prev;
  logic               np_able_q, an_able_q;
  logic               lh_pd_fault, lh_page_rx;
  logic [1:0]         func;
  logic [EV_W-1:0]    ev_status, ev_mask;
  logic               acked;
  logic [3:0]         idx;
  logic               wr_hit, rd_hit;
  logic [15:0]        rd_val;
  logic               rd_ok;

  // Writes land at the answer edge; a read clears flags where its data is captured
  assign idx    = avs_address[ADDR_W-1:2];
  assign wr_hit = avs_write & ~avs_waitrequest & avs_byteenable[0] & avs_byteenable[1];
  assign rd_hit = avs_read & avs_waitrequest;

  // ----------------------------------------------------------------
  // Bus handshake: one wait cycle, answer on the second edge
  // ----------------------------------------------------------------
  // Waitrequest drops for exactly one cycle after a request is seen
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
    end else if ((avs_read | avs_write) & avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Partner ability and receive page capture
  // ----------------------------------------------------------------
  // Engine loads whole words; all fields read-only to software
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      partner <= '0;
      rx_page <= '0;
    end else begin
      if (partner_load) partner <= partner_in;
      if (rx_page_load) rx_page <= rx_page_in;
    end
  end

  // Expansion level bits track the engine
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      np_able_q <= 1'b0;
      an_able_q <= 1'b0;
    end else begin
      np_able_q <= exp_in.partner_np_able;
      an_able_q <= exp_in.partner_an_able;
    end
  end

  // ----------------------------------------------------------------
  // Latching-high expansion bits
  // ----------------------------------------------------------------
  // Read clears, but a live condition sets again in the same cycle
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      lh_pd_fault <= 1'b0;
      lh_page_rx  <= 1'b0;
    end else begin
      if (exp_in.pd_fault) lh_pd_fault <= 1'b1;
      else if (rd_hit && idx == IDX_NEGOTIATION_EXPANSION)
        lh_pd_fault <= 1'b0;
      if (exp_in.page_rx) lh_page_rx <= 1'b1;
      else if (rd_hit && idx == IDX_NEGOTIATION_EXPANSION)
        lh_page_rx <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Transmit page and toggle
  // ----------------------------------------------------------------
  // Toggle flips each time the engine sends a page
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tx_page          <= '0;
      tx_page.msg_page <= TX_MSG_RESET;
      tx_page.code     <= TX_CODE_RESET;
      tx_toggle_prev   <= 1'b1;
    end else begin
      if (tx_page_sent) tx_toggle_prev <= tx_page.toggle;
      tx_page.toggle <= ~tx_toggle_prev;
      if (wr_hit && idx == IDX_NEXT_PAGE_TRANSMIT) begin
        tx_page.next_page <= avs_writedata[15];
        tx_page.msg_page  <= avs_writedata[13];
        tx_page.comply    <= avs_writedata[12];
        tx_page.code      <= avs_writedata[10:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Indirect device access
  // ----------------------------------------------------------------
  // Function 00 sets the address, otherwise data passes through
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      func                 <= FUNC_ADDRESS;
      target_device_select <= '0;
      indirect_address     <= '0;
      indirect_wr          <= 1'b0;
      indirect_wdata       <= '0;
    end else begin
      indirect_wr <= 1'b0;
      if (wr_hit && idx == IDX_INDIRECT_ACCESS_CONTROL) begin
        func                 <= avs_writedata[15:14];
        target_device_select <= avs_writedata[4:0];
      end
      if (wr_hit && idx == IDX_INDIRECT_ADDRESS_DATA) begin
        if (func == FUNC_ADDRESS) begin
          indirect_address <= avs_writedata[15:0];
        end else begin
          indirect_wr    <= 1'b1;
          indirect_wdata <= avs_writedata[15:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  // Sticky events, write one to clear; a new event wins over clear
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ev_status <= '0;
      ev_mask   <= '0;
      irq       <= 1'b0;
    end else begin
      for (int i = 0; i < EV_W; i++) begin
        if ((i == EV_PD_FAULT && exp_in.pd_fault) || (i == EV_PAGE_RX && exp_in.page_rx))
          ev_status[i] <= 1'b1;
        else if (wr_hit && idx == IDX_EVENT_STATUS && avs_writedata[i])
          ev_status[i] <= 1'b0;
      end
      if (wr_hit && idx == IDX_EVENT_MASK) ev_mask <= avs_writedata[EV_W-1:0];
      irq <= |(ev_status & ev_mask);
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // Reserved bits read zero; unmapped index answers a slave error
  always_comb begin
    rd_val = '0;
    rd_ok  = 1'b1;
    case (idx)
      IDX_PARTNER_BASE_ABILITY: rd_val = {partner.next_page, partner.ack,
        partner.remote_fault, 1'b0, partner.pause, partner.t4, partner.speeds,
        SELECTOR_8023};
      IDX_NEGOTIATION_EXPANSION: rd_val = {9'h000, 1'b1, 1'b1, lh_pd_fault,
        np_able_q, 1'b1, lh_page_rx, an_able_q};
      IDX_NEXT_PAGE_TRANSMIT: rd_val = {tx_page.next_page, 1'b0, tx_page.msg_page,
        tx_page.comply, tx_page.toggle, tx_page.code};
      IDX_NEXT_PAGE_RECEIVE: rd_val = rx_page;
      IDX_INDIRECT_ACCESS_CONTROL: rd_val = {func, 9'h000, target_device_select};
      IDX_INDIRECT_ADDRESS_DATA: rd_val = (func == FUNC_ADDRESS) ? indirect_address
                                                                  : indirect_rdata;
      IDX_EVENT_STATUS: rd_val = {{(16-EV_W){1'b0}}, ev_status};
      IDX_EVENT_MASK:   rd_val = {{(16-EV_W){1'b0}}, ev_mask};
      default: rd_ok = 1'b0;
    endcase
  end

  // Read data and response registered for the answering edge
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      avs_readdata <= '0;
      avs_response <= 2'h0;
    end else if ((avs_read | avs_write) & avs_waitrequest) begin
      avs_readdata <= avs_read ? {16'h0000, rd_val} : 32'h0000_0000;
      avs_response <= rd_ok ? 2'h0 : 2'h2;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_lp_reset_clear;
    @(posedge core_clk) $fell(reset) |-> (partner == '0) && (rx_page == '0);
  endproperty
  a_lp_reset_clear: assert property (p_lp_reset_clear) else $error("partner not clear");

  property p_partner_load;
    @(posedge core_clk) disable iff (reset) partner_load |=> partner == $past(partner_in);
  endproperty
  a_partner_load: assert property (p_partner_load) else $error("partner not loaded");

  property p_pd_latch;
    @(posedge core_clk) disable iff (reset)
      exp_in.pd_fault |=> lh_pd_fault;
  endproperty
  a_pd_latch: assert property (p_pd_latch) else $error("fault not latched");

  property p_pd_hold;
    @(posedge core_clk) disable iff (reset)
      lh_pd_fault && !(rd_hit && idx == IDX_NEGOTIATION_EXPANSION) |=> lh_pd_fault;
  endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("fault dropped early");

  property p_page_latch;
    @(posedge core_clk) disable iff (reset)
      exp_in.page_rx || (lh_page_rx && !(rd_hit && idx == IDX_NEGOTIATION_EXPANSION))
      |=> lh_page_rx;
  endproperty
  a_page_latch: assert property (p_page_latch) else $error("page flag lost");

  property p_clear_on_read;
    @(posedge core_clk) disable iff (reset)
      rd_hit && idx == IDX_NEGOTIATION_EXPANSION && !exp_in.page_rx |=> !lh_page_rx;
  endproperty
  a_clear_on_read: assert property (p_clear_on_read) else $error("flag not cleared");

  property p_exp_const;
    @(posedge core_clk) disable iff (reset)
      rd_hit && idx == IDX_NEGOTIATION_EXPANSION
      |=> avs_readdata[6] && avs_readdata[5] && avs_readdata[2];
  endproperty
  a_exp_const: assert property (p_exp_const) else $error("expansion constants");

  property p_toggle;
    @(posedge core_clk) disable iff (reset)
      tx_page_sent ##1 !tx_page_sent |=> tx_page.toggle == !$past(tx_page.toggle, 2);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle wrong");

  property p_addr_write;
    @(posedge core_clk) disable iff (reset)
      wr_hit && idx == IDX_INDIRECT_ADDRESS_DATA && func == FUNC_ADDRESS
      |=> !indirect_wr && indirect_address == $past(avs_writedata[15:0]);
  endproperty
  a_addr_write: assert property (p_addr_write) else $error("address not set");

  property p_wait_one;
    @(posedge core_clk) disable iff (reset)
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait timing"); // Bus answer timing

  // Field behaviour as seen through the bus and the engine strobes
  property p_partner_ro;
    @(posedge core_clk) disable iff (reset)
      wr_hit && idx == IDX_PARTNER_BASE_ABILITY && !partner_load
      |=> partner == $past(partner);
  endproperty
  a_partner_ro: assert property (p_partner_ro) else $error("partner word written");

  property p_partner_read;
    @(posedge core_clk) disable iff (reset)
      rd_hit && idx == IDX_PARTNER_BASE_ABILITY
      |=> avs_readdata[9] == $past(partner.t4)
          && avs_readdata[13] == $past(partner.remote_fault);
  endproperty
  a_partner_read: assert property (p_partner_read) else $error("partner bits");

  property p_rx_load;
    @(posedge core_clk) disable iff (reset)
      rx_page_load |=> rx_page == $past(rx_page_in);
  endproperty
  a_rx_load: assert property (p_rx_load) else $error("receive page not loaded");

  property p_rx_ro;
    @(posedge core_clk) disable iff (reset)
      wr_hit && idx == IDX_NEXT_PAGE_RECEIVE && !rx_page_load |=> rx_page == $past(rx_page);
  endproperty
  a_rx_ro: assert property (p_rx_ro) else $error("receive page written");

  property p_tx_write;
    @(posedge core_clk) disable iff (reset)
      wr_hit && idx == IDX_NEXT_PAGE_TRANSMIT
      |=> tx_page.code == $past(avs_writedata[10:0])
          && tx_page.comply == $past(avs_writedata[12]);
  endproperty
  a_tx_write: assert property (p_tx_write) else $error("tx page not written");

  property p_ctrl_write;
    @(posedge core_clk) disable iff (reset)
      wr_hit && idx == IDX_INDIRECT_ACCESS_CONTROL
      |=> func == $past(avs_writedata[15:14])
          && target_device_select == $past(avs_writedata[4:0]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control not written");

  property p_data_write;
    @(posedge core_clk) disable iff (reset)
      wr_hit && idx == IDX_INDIRECT_ADDRESS_DATA && func != FUNC_ADDRESS
      |=> indirect_wr && indirect_wdata == $past(avs_writedata[15:0]);
  endproperty
  a_data_write: assert property (p_data_write) else $error("data write missing");

  property p_pd_clear;
    @(posedge core_clk) disable iff (reset)
      rd_hit && idx == IDX_NEGOTIATION_EXPANSION && !exp_in.pd_fault |=> !lh_pd_fault;
  endproperty
  a_pd_clear: assert property (p_pd_clear) else $error("fault flag not cleared");

  property p_able_read;
    @(posedge core_clk) disable iff (reset)
      rd_hit && idx == IDX_NEGOTIATION_EXPANSION
      |=> avs_readdata[3] == $past(np_able_q) && avs_readdata[0] == $past(an_able_q);
  endproperty
  a_able_read: assert property (p_able_read) else $error("partner able bits");

  c_page_rx:    cover property (@(posedge core_clk) disable iff (reset) exp_in.page_rx);
  c_irq:        cover property (@(posedge core_clk) disable iff (reset) $rose(irq));
  c_data_write: cover property (@(posedge core_clk) disable iff (reset) indirect_wr);
  c_tx_sent:    cover property (@(posedge core_clk) disable iff (reset) tx_page_sent);
  c_exp_read:   cover property (@(posedge core_clk) disable iff (reset)
                                rd_hit && idx == IDX_NEGOTIATION_EXPANSION);

endmodule : autoneg_nextpage_mmd_regs

// >>> hw/an_regs_pkg.sv
// Package: register map, field layout and types for the negotiation register group
package an_regs_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_PARTNER_BASE_ABILITY    = 4'h5;
  localparam logic [3:0] IDX_NEGOTIATION_EXPANSION   = 4'h6;
  localparam logic [3:0] IDX_NEXT_PAGE_TRANSMIT      = 4'h7;
  localparam logic [3:0] IDX_NEXT_PAGE_RECEIVE       = 4'h8;
  localparam logic [3:0] IDX_INDIRECT_ACCESS_CONTROL = 4'hD;
  localparam logic [3:0] IDX_INDIRECT_ADDRESS_DATA   = 4'hE;
  localparam logic [3:0] IDX_EVENT_STATUS            = 4'h9;
  localparam logic [3:0] IDX_EVENT_MASK              = 4'hA;

  // ----------------------------------------------------------------
  // Field positions and constants
  // ----------------------------------------------------------------
  localparam int          ADDR_W          = 6;
  localparam logic [4:0]  SELECTOR_8023   = 5'h01;
  localparam logic [10:0] TX_CODE_RESET   = 11'h001;
  localparam logic        TX_MSG_RESET    = 1'b1;
  localparam logic [1:0]  FUNC_ADDRESS    = 2'h0;
  localparam logic [1:0]  FUNC_DATA       = 2'h1;
  localparam logic [4:0]  DEVSEL_PCS      = 5'h03;
  localparam logic [4:0]  DEVSEL_AUTONEG  = 5'h07;
  localparam int          EV_PD_FAULT     = 0;
  localparam int          EV_PAGE_RX      = 1;
  localparam int          EV_W            = 2;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        next_page;
    logic        ack;
    logic        remote_fault;
    logic [1:0]  pause;
    logic        t4;
    logic [3:0]  speeds;
  } partner_base_t;

  typedef struct packed {
    logic        next_page;
    logic        ack;
    logic        msg_page;
    logic        comply;
    logic        toggle;
    logic [10:0] code;
  } page_t;

  typedef struct packed {
    logic        pd_fault;
    logic        page_rx;
    logic        partner_np_able;
    logic        partner_an_able;
  } expansion_in_t;

endpackage : an_regs_pkg

// >>> bench/mmd_device_model.sv
// Behavioural model of the manageable devices reached through indirect access
`timescale 1ns/100ps
module mmd_device_model (
  // Clock
  input  wire logic        core_clk,
  // Indirect access side
  input  wire logic [4:0]  target_device_select,
  input  wire logic [15:0] indirect_address,
  input  wire logic        indirect_wr,
  input  wire logic [15:0] indirect_wdata,
  output logic      [15:0] indirect_rdata
);
  logic [15:0] mem [0:15];

  // Bit 2 of the select keeps the two test devices apart
  always @(posedge core_clk) begin
    if (indirect_wr === 1'b1) begin
      mem[{target_device_select[2], indirect_address[2:0]}] <= indirect_wdata;
    end
  end

  // Read path is combinational, as the block samples it at the request edge
  assign indirect_rdata = mem[{target_device_select[2], indirect_address[2:0]}];
endmodule : mmd_device_model

// >>> bench/autoneg_nextpage_mmd_regs_tb.sv
// Self-checking bench for the negotiation and indirect access register group
`timescale 1ns/100ps
module autoneg_nextpage_mmd_regs_tb import an_regs_pkg::*;;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic              core_clk = 1'b0;
  logic              reset = 1'b1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic              avs_read = 1'b0;
  logic              avs_write = 1'b0;
  logic [31:0]       avs_writedata = '0;
  logic [3:0]        avs_byteenable = '0;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  logic [1:0]        avs_response;
  partner_base_t     partner_in = '0;
  page_t             rx_page_in = '0;
  expansion_in_t     exp_in = '0;
  logic              partner_load = 1'b0;
  logic              rx_page_load = 1'b0;
  logic              tx_page_sent = 1'b0;
  logic [4:0]        target_device_select;
  logic [15:0]       indirect_address;
  logic [15:0]       indirect_wdata;
  logic [15:0]       indirect_rdata;
  logic              indirect_wr;
  logic              irq;
  int                err_count = 0;
  int                num_checks = 0;
  logic [35:0]       expq [$];
  logic [31:0]       lfsr_state = 32'h0001690E;

  always #25 core_clk = ~core_clk;

  autoneg_nextpage_mmd_regs u_autoneg_nextpage_mmd_regs (
    .core_clk(core_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .partner_in(partner_in), .partner_load(partner_load),
    .rx_page_in(rx_page_in), .rx_page_load(rx_page_load), .exp_in(exp_in),
    .tx_page_sent(tx_page_sent), .target_device_select(target_device_select),
    .indirect_address(indirect_address), .indirect_wr(indirect_wr),
    .indirect_wdata(indirect_wdata), .indirect_rdata(indirect_rdata), .irq(irq));

  mmd_device_model u_mmd_device_model (
    .core_clk(core_clk), .target_device_select(target_device_select),
    .indirect_address(indirect_address), .indirect_wr(indirect_wr),
    .indirect_wdata(indirect_wdata), .indirect_rdata(indirect_rdata));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic chk(input string nm, input logic [17:0] exp, input logic [17:0] seen);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One bus cycle, held until waitrequest is sampled low
  task automatic bus(input logic [3:0] idx, input logic wr, input logic [15:0] d,
                     input logic [3:0] be);
    int n;
    n = 0;
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {16'h0000, d};
    avs_byteenable <= be;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    chk("bus wait edges", 18'h00002, n[17:0]);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask : bus

  task automatic wr(input logic [3:0] idx, input logic [15:0] d);
    bus(idx, 1'b1, d, 4'hF);
  endtask : wr

  // Notes the expected answer, then reads; the watcher compares
  task automatic rd(input logic [3:0] idx, input logic [15:0] d,
                    input logic [1:0] resp = 2'b00, input logic [15:0] m = 16'hFFFF);
    expq.push_back({2'b11, m, resp, d});
    bus(idx, 1'b0, 16'h0000, 4'hF);
  endtask : rd

  // One-cycle strobe on the engine side: 0 partner, 1 receive page, 2 page sent
  task automatic strobe(input int k);
    partner_load <= (k == 0);
    rx_page_load <= (k == 1);
    tx_page_sent <= (k == 2);
    @(posedge core_clk);
    {partner_load, rx_page_load, tx_page_sent} <= 3'h0;
    @(posedge core_clk);
  endtask : strobe

  task automatic close_out();
    if (expq.size() != 0) err_count++;
    $display("Checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  // Watcher: read data stand at the answer edge only
  always @(posedge core_clk) begin
    logic [35:0] e;
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      e = expq.pop_front();
      chk("readdata", e[17:0] & e[35:18], {avs_response, avs_readdata[15:0]} & e[35:18]);
      chk("readdata upper", 18'h00000, {2'b00, avs_readdata[31:16]});
    end
  end

  // Watchdog, far beyond the fewer than two hundred cycles the run needs
  initial begin
    #250000;
    err_count++;
    close_out();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    partner_base_t pb;
    page_t         pg;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    rd(IDX_PARTNER_BASE_ABILITY, 16'h0001);
    rd(IDX_NEGOTIATION_EXPANSION, 16'h0064);
    rd(IDX_NEXT_PAGE_TRANSMIT, 16'h2001);
    rd(IDX_NEXT_PAGE_RECEIVE, 16'h0000);
    rd(IDX_INDIRECT_ACCESS_CONTROL, 16'h0000);
    // Every pause code with random neighbours
    for (int i = 0; i < 4; i++) begin
      lfsr_state = lfsr_next(lfsr_state);
      pb = partner_base_t'(lfsr_state[9:0]);
      pb.pause = i[1:0];
      partner_in <= pb;
      strobe(0);
      wr(IDX_PARTNER_BASE_ABILITY, 16'h0000);
      rd(IDX_PARTNER_BASE_ABILITY, {pb[9:7], 1'b0, pb[6:0], SELECTOR_8023});
    end
    lfsr_state = lfsr_next(lfsr_state);
    pg = page_t'(lfsr_state[15:0]);
    rx_page_in <= pg;
    strobe(1);
    wr(IDX_NEXT_PAGE_RECEIVE, ~pg);
    rd(IDX_NEXT_PAGE_RECEIVE, pg);
    // Reset in mid-run brings loaded words back to their reset values
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    rd(IDX_PARTNER_BASE_ABILITY, 16'h0001);
    rd(IDX_NEXT_PAGE_RECEIVE, 16'h0000);
    // Transmit page: toggle and reserved bit ignore writes
    wr(IDX_NEXT_PAGE_TRANSMIT, 16'hFFFF);
    rd(IDX_NEXT_PAGE_TRANSMIT, 16'hB7FF);
    strobe(2);
    rd(IDX_NEXT_PAGE_TRANSMIT, 16'hBFFF);
    strobe(2);
    bus(IDX_NEXT_PAGE_TRANSMIT, 1'b1, 16'h0000, 4'h1);
    rd(IDX_NEXT_PAGE_TRANSMIT, 16'hB7FF);
    // Events while masked, then latched bits and the interrupt
    wr(IDX_EVENT_MASK, 16'h0000);
    exp_in <= 4'hF;
    @(posedge core_clk);
    exp_in <= 4'hB;
    repeat (3) @(posedge core_clk);
    chk("irq masked", {17'h00000, irq}, 18'h00000);
    rd(IDX_NEGOTIATION_EXPANSION, 16'h007F);
    rd(IDX_NEGOTIATION_EXPANSION, 16'h007D);
    exp_in <= 4'h3;
    rd(IDX_NEGOTIATION_EXPANSION, 16'h007D);
    rd(IDX_NEGOTIATION_EXPANSION, 16'h006D);
    rd(IDX_EVENT_STATUS, 16'h0003);
    wr(IDX_EVENT_MASK, 16'h0001);
    repeat (2) @(posedge core_clk);
    chk("irq raised", {17'h00000, irq}, 18'h00001);
    wr(IDX_EVENT_STATUS, 16'h0001);
    repeat (2) @(posedge core_clk);
    chk("irq cleared", {17'h00000, irq}, 18'h00000);
    rd(IDX_EVENT_STATUS, 16'h0002);
    // Indirect access to two devices at the same address
    wr(IDX_INDIRECT_ACCESS_CONTROL, {FUNC_ADDRESS, 9'h000, DEVSEL_PCS});
    chk("device select", {13'h0000, target_device_select}, {13'h0000, DEVSEL_PCS});
    wr(IDX_INDIRECT_ADDRESS_DATA, 16'h0005);
    chk("indirect address", {2'b00, indirect_address}, 18'h00005);
    wr(IDX_INDIRECT_ACCESS_CONTROL, {FUNC_DATA, 9'h000, DEVSEL_PCS});
    wr(IDX_INDIRECT_ADDRESS_DATA, 16'hBEEF);
    wr(IDX_INDIRECT_ACCESS_CONTROL, {FUNC_ADDRESS, 9'h000, DEVSEL_AUTONEG});
    wr(IDX_INDIRECT_ADDRESS_DATA, 16'h0005);
    wr(IDX_INDIRECT_ACCESS_CONTROL, {FUNC_DATA, 9'h000, DEVSEL_AUTONEG});
    wr(IDX_INDIRECT_ADDRESS_DATA, 16'hCAFE);
    rd(IDX_INDIRECT_ADDRESS_DATA, 16'hCAFE);
    rd(IDX_INDIRECT_ACCESS_CONTROL, {FUNC_DATA, 9'h000, DEVSEL_AUTONEG});
    wr(IDX_INDIRECT_ACCESS_CONTROL, {FUNC_DATA, 9'h000, DEVSEL_PCS});
    rd(IDX_INDIRECT_ADDRESS_DATA, 16'hBEEF);
    wr(IDX_INDIRECT_ACCESS_CONTROL, {FUNC_ADDRESS, 9'h1FF, DEVSEL_PCS});
    rd(IDX_INDIRECT_ADDRESS_DATA, 16'h0005);
    rd(IDX_INDIRECT_ACCESS_CONTROL, {FUNC_ADDRESS, 9'h000, DEVSEL_PCS});
    // Unmapped index answers with an error
    wr(4'h3, 16'hFFFF);
    rd(4'h3, 16'h0000, 2'b10, 16'h0000);
    close_out();
  end
endmodule : autoneg_nextpage_mmd_regs_tb
